// ==== hdl/acc_clk_div.sv ====
`timescale 1ns/1ps
// Half-period enable generator for the conversion clock
module acc_clk_div #(
   parameter int CNT_W = 6
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic restart,
   input wire logic [CNT_W-1:0] halfClks,
   output logic tick
);
   logic [CNT_W-1:0] cnt_q;

   // Restart realigns the phase so every conversion sees whole periods
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (restart || cnt_q == halfClks - CNT_W'(1)) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   assign tick = !restart && (cnt_q == halfClks - CNT_W'(1));
endmodule

// ==== hdl/acc_pkg.sv ====
package acc_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0] OFS_CTRL_ZERO = 8'h00;
   localparam logic [7:0] OFS_CTRL_ONE = 8'h04;
   localparam logic [7:0] OFS_RES_HIGH = 8'h08;
   localparam logic [7:0] OFS_RES_LOW = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // Control register zero fields
   localparam int CZ_ENABLE_BIT = 0;
   localparam int CZ_GO_BIT = 1;
   localparam int CZ_CHAN_LSB = 2;
   localparam int CZ_CHAN_MSB = 6;
   localparam logic [7:0] CZ_RESET = 8'h00;

   // Control register one fields
   localparam int CO_POSREF_LSB = 0;
   localparam int CO_POSREF_MSB = 1;
   localparam int CO_NEGREF_BIT = 2;
   localparam int CO_CLKSEL_LSB = 4;
   localparam int CO_CLKSEL_MSB = 6;
   localparam int CO_JUSTIFY_BIT = 7;
   localparam logic [7:0] CO_RESET = 8'h00;
   localparam logic [7:0] CO_WRITE_MASK = 8'hF7;

   // Status register fields
   localparam int ST_DONE_BIT = 0;
   localparam int ST_IRQEN_BIT = 1;

   // Result register reset
   localparam logic [7:0] RES_RESET = 8'h00;

   // Channel codes
   localparam logic [4:0] CHAN_LAST_EXT = 5'h0D;
   localparam logic [4:0] CHAN_TEMP = 5'h1D;
   localparam logic [4:0] CHAN_DAC = 5'h1E;
   localparam logic [4:0] CHAN_FVR = 5'h1F;

   // Positive reference codes
   localparam logic [1:0] POSREF_RESERVED = 2'b01;

   // Conversion clock codes; the low two bits 11 mean the RC oscillator
   localparam logic [2:0] CS_DIV2 = 3'b000;
   localparam logic [2:0] CS_DIV8 = 3'b001;
   localparam logic [2:0] CS_DIV32 = 3'b010;
   localparam logic [2:0] CS_DIV4 = 3'b100;
   localparam logic [2:0] CS_DIV16 = 3'b101;
   localparam logic [2:0] CS_DIV64 = 3'b110;
   localparam logic [1:0] CS_RC_LOW = 2'b11;

   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int RC_TAD_NS = 1600;
   localparam int RC_HALF_CLKS = RC_TAD_NS / (2 * CLK_PERIOD_NS);
   localparam int INSTR_CYCLE_CLKS = 4;
   localparam int RESULT_BITS = 10;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT_INSTR = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONVERT = 3'b011,
      ST_FINISH = 3'b100
   } acc_state_t;
endpackage

// ==== hdl/acc_top.sv ====
`timescale 1ns/1ps
// Operation
// - Conversion continues through sleep only with the RC clock selected.
// - With RC clock, start waits one extra instruction cycle.
// - Sleep, interrupt enabled: completion raises the wake request.
// - Sleep, interrupt disabled: power down after completion, enable stays set.
// - Sleep with a divided clock aborts and powers down, enable stays set.
// - Special event trigger sets go flag and clears timer one; here go is set only while enable is set, timer one is cleared regardless.
// - Channel codes 0 to 13 route external inputs 0 to 13.
// - Codes 14-28 none, 29 temperature, 30 DAC, 31 fixed reference.
// - Go bit starts on write one, reads busy, clears at completion; here a start needs enable written one in the same write.
// - Enable bit powers the converter; clear means no operating current.
// - Justify one: right, high six zero; zero: left, low six zero.
// - Clock select picks Fosc divider or the RC oscillator for x11.
// - Negative reference is ground at zero, external pin at one.
// - Positive reference: supply, reserved, external pin, fixed reference.
// - Left justified, high byte holds the eight result MSBs.
// - Control zero bit 7 and control one bit 3 read zero.
// - Completion clears go, sets done flag, loads both result bytes.
// - Software abort stores partial result, unresolved bits copy last bit.
// - Full conversion takes eleven and a half conversion clock periods.
// - Done flag sets every conversion regardless of interrupt enable.
module acc_top
   import acc_pkg::*;
#(
   parameter int RC_HALF = acc_pkg::RC_HALF_CLKS
) (
   input wire logic core_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Processor and trigger side
   input wire logic sleepActive,
   input wire logic specialEventTrig,
   output logic timerOneClear,
   output logic wakeRequest,
   output logic convDonePulse,
   // Analog core side
   input wire logic cmpOut,
   output logic analogPowerOn,
   output logic sampleActive,
   output logic [9:0] trialCode,
   output logic [3:0] extChannel,
   output logic extChannelEn,
   output logic tempSel,
   output logic dacSel,
   output logic fvrSel,
   output logic negRefExt,
   output logic [1:0] posRefSel,
   output logic posRefValid
);
   import acc_pkg::*;

   logic [7:0] ctrlZero_q;
   logic [7:0] ctrlOne_q;
   logic [7:0] resHigh_q;
   logic [7:0] resLow_q;
   logic doneFlag_q;
   logic irqEn_q;
   logic powerDown_q;
   logic wake_q;
   logic donePulse_q;
   logic timerClr_q;
   logic [7:0] addr_q;
   logic wrPend_q;
   logic rdPend_q;
   acc_state_t state_q;
   logic [9:0] sar_q;
   logic [9:0] trial_q;
   logic [3:0] bitIdx_q;
   logic bitsDone_q;
   logic tadPhase_q;
   logic [2:0] instrCnt_q;
   logic divRestart;
   logic tick;
   logic [5:0] halfClks;
   logic rcSel;
   logic busy;
   logic enable;
   logic wrCtrlZero;
   logic swStart;
   logic swAbort;
   logic hwStart;
   logic startReq;
   logic finish;
   logic sleepAbort;
   logic [9:0] partial;
   logic [9:0] loadVal;
   logic loadRes;

   assign enable = ctrlZero_q[CZ_ENABLE_BIT];
   assign busy = (state_q != ST_IDLE);
   assign rcSel = (ctrlOne_q[CO_CLKSEL_LSB +: 2] == CS_RC_LOW);

   // Bus address phase capture; zero wait states, always OKAY
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         addr_q <= 8'h00;
         wrPend_q <= 1'b0;
         rdPend_q <= 1'b0;
      end else if (hready) begin
         addr_q <= haddr[7:0];
         wrPend_q <= hsel && htrans[1] && hwrite;
         rdPend_q <= hsel && htrans[1] && !hwrite;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Read mux in the data phase; unmapped addresses read zero
   always_comb begin
      hrdata = 32'h0000_0000;
      if (rdPend_q) begin
         case (addr_q)
            OFS_CTRL_ZERO: hrdata = {24'h00_0000, 1'b0, ctrlZero_q[6:2], busy, enable};
            OFS_CTRL_ONE: hrdata = {24'h00_0000, ctrlOne_q & CO_WRITE_MASK};
            OFS_RES_HIGH: hrdata = {24'h00_0000, resHigh_q};
            OFS_RES_LOW: hrdata = {24'h00_0000, resLow_q};
            OFS_STATUS: hrdata = {30'h0000_0000, irqEn_q, doneFlag_q};
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Start and abort requests
   assign wrCtrlZero = wrPend_q && (addr_q == OFS_CTRL_ZERO);
   assign swStart = wrCtrlZero && hwdata[CZ_GO_BIT] && hwdata[CZ_ENABLE_BIT];
   assign swAbort = wrCtrlZero && !hwdata[CZ_GO_BIT] && busy;
   assign hwStart = specialEventTrig && enable;
   assign startReq = !busy && (swStart || hwStart) && !powerDown_q;
   // A divided clock cannot survive sleep, so the conversion is dropped
   assign sleepAbort = busy && sleepActive && !rcSel;
   assign finish = (state_q == ST_FINISH) && tick && tadPhase_q;

   // Control register zero; go is not stored, it is the busy state
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrlZero_q <= CZ_RESET;
      end else if (wrCtrlZero) begin
         ctrlZero_q <= {1'b0, hwdata[6:2], 1'b0, hwdata[CZ_ENABLE_BIT]};
      end
   end

   // Control register one
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrlOne_q <= CO_RESET;
      end else if (wrPend_q && addr_q == OFS_CTRL_ONE) begin
         ctrlOne_q <= hwdata[7:0] & CO_WRITE_MASK;
      end
   end

   // Done flag and interrupt enable; a completion beats a software clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         doneFlag_q <= 1'b0;
         irqEn_q <= 1'b0;
      end else begin
         if (loadRes && !swAbort) begin
            doneFlag_q <= 1'b1;
         end else if (wrPend_q && addr_q == OFS_STATUS) begin
            doneFlag_q <= hwdata[ST_DONE_BIT];
         end
         if (wrPend_q && addr_q == OFS_STATUS) begin
            irqEn_q <= hwdata[ST_IRQEN_BIT];
         end
      end
   end

   // Conversion clock select to half-period length
   always_comb begin
      case (ctrlOne_q[CO_CLKSEL_MSB:CO_CLKSEL_LSB])
         CS_DIV2: halfClks = 6'd1;
         CS_DIV4: halfClks = 6'd2;
         CS_DIV8: halfClks = 6'd4;
         CS_DIV16: halfClks = 6'd8;
         CS_DIV32: halfClks = 6'd16;
         CS_DIV64: halfClks = 6'd32;
         default: halfClks = 6'(RC_HALF);
      endcase
   end

   acc_clk_div #(
      .CNT_W(6)
   ) u_div (
      .core_clk(core_clk),
      .rst(rst),
      .restart(divRestart),
      .halfClks(halfClks),
      .tick(tick)
   );

   assign divRestart = (startReq && !rcSel)
      || (state_q == ST_WAIT_INSTR && instrCnt_q == 3'(INSTR_CYCLE_CLKS - 1));

   // Sequencer: half period of sampling, ten bit periods, one closing period
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         instrCnt_q <= 3'd0;
         tadPhase_q <= 1'b0;
         bitIdx_q <= 4'd0;
      end else if (swAbort || sleepAbort) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (startReq) begin
                  instrCnt_q <= 3'd0;
                  state_q <= rcSel ? ST_WAIT_INSTR : ST_SAMPLE;
               end
            end
            ST_WAIT_INSTR: begin
               instrCnt_q <= instrCnt_q + 3'd1;
               if (instrCnt_q == 3'(INSTR_CYCLE_CLKS - 1)) begin
                  state_q <= ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               if (tick) begin
                  state_q <= ST_CONVERT;
                  bitIdx_q <= 4'(RESULT_BITS - 1);
                  tadPhase_q <= 1'b0;
               end
            end
            ST_CONVERT: begin
               if (tick) begin
                  tadPhase_q <= !tadPhase_q;
                  if (tadPhase_q) begin
                     if (bitIdx_q == 4'd0) begin
                        state_q <= ST_FINISH;
                     end else begin
                        bitIdx_q <= bitIdx_q - 4'd1;
                     end
                  end
               end
            end
            ST_FINISH: begin
               if (tick) begin
                  tadPhase_q <= !tadPhase_q;
                  if (tadPhase_q) begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Successive approximation register and trial code
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sar_q <= 10'h000;
         trial_q <= 10'h000;
         bitsDone_q <= 1'b0;
      end else if (state_q == ST_SAMPLE && tick) begin
         sar_q <= 10'h000;
         trial_q <= 10'h200;
         bitsDone_q <= 1'b0;
      end else if (state_q == ST_CONVERT && tick && tadPhase_q) begin
         sar_q[bitIdx_q] <= cmpOut;
         bitsDone_q <= 1'b1;
         trial_q[bitIdx_q] <= cmpOut;
         if (bitIdx_q != 4'd0) begin
            trial_q[bitIdx_q - 4'd1] <= 1'b1;
         end
      end
   end

   // Partial value: unresolved bits repeat the last resolved one
   always_comb begin
      partial = sar_q;
      for (int i = 0; i < RESULT_BITS; i++) begin
         if (state_q == ST_CONVERT && i <= int'(bitIdx_q)) begin
            partial[i] = bitsDone_q ? sar_q[bitIdx_q + 4'd1] : 1'b0;
         end
      end
   end

   assign loadRes = finish || (swAbort && (state_q == ST_CONVERT || state_q == ST_FINISH));
   assign loadVal = finish ? sar_q : partial;

   // Result bytes, formatted at load time
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         resHigh_q <= RES_RESET;
         resLow_q <= RES_RESET;
      end else if (loadRes) begin
         if (ctrlOne_q[CO_JUSTIFY_BIT]) begin
            resHigh_q <= {6'h00, loadVal[9:8]};
            resLow_q <= loadVal[7:0];
         end else begin
            resHigh_q <= loadVal[9:2];
            resLow_q <= {loadVal[1:0], 6'h00};
         end
      end else if (wrPend_q && addr_q == OFS_RES_HIGH) begin
         resHigh_q <= hwdata[7:0];
      end else if (wrPend_q && addr_q == OFS_RES_LOW) begin
         resLow_q <= hwdata[7:0];
      end
   end

   // Sleep power-down and wake; released when the processor wakes
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         powerDown_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         wake_q <= finish && sleepActive && irqEn_q;
         if (!sleepActive) begin
            powerDown_q <= 1'b0;
         end else if (!rcSel) begin
            powerDown_q <= 1'b1;
         end else if (finish && !irqEn_q) begin
            powerDown_q <= 1'b1;
         end
      end
   end

   // Event pulses toward the system
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         donePulse_q <= 1'b0;
         timerClr_q <= 1'b0;
      end else begin
         donePulse_q <= finish;
         timerClr_q <= specialEventTrig;
      end
   end

   assign wakeRequest = wake_q;
   assign convDonePulse = donePulse_q;
   assign timerOneClear = timerClr_q;
   assign analogPowerOn = enable && !powerDown_q;
   assign sampleActive = (state_q == ST_SAMPLE) || (state_q == ST_WAIT_INSTR);
   assign trialCode = trial_q;

   // Channel routing decode
   assign extChannel = ctrlZero_q[5:2];
   assign extChannelEn = (ctrlZero_q[CZ_CHAN_MSB:CZ_CHAN_LSB] <= CHAN_LAST_EXT);
   assign tempSel = (ctrlZero_q[CZ_CHAN_MSB:CZ_CHAN_LSB] == CHAN_TEMP);
   assign dacSel = (ctrlZero_q[CZ_CHAN_MSB:CZ_CHAN_LSB] == CHAN_DAC);
   assign fvrSel = (ctrlZero_q[CZ_CHAN_MSB:CZ_CHAN_LSB] == CHAN_FVR);

   // Reference selection
   assign negRefExt = ctrlOne_q[CO_NEGREF_BIT];
   assign posRefSel = ctrlOne_q[CO_POSREF_MSB:CO_POSREF_LSB];
   assign posRefValid = (ctrlOne_q[CO_POSREF_MSB:CO_POSREF_LSB] != POSREF_RESERVED);
endmodule

// ==== verification/acc_analog_model.sv ====
`timescale 1ns/1ps
// Behavioural sample-and-hold plus comparator facing the sequencer
module acc_analog_model (
   input wire logic core_clk,
   input wire logic analogPowerOn,
   input wire logic sampleActive,
   input wire logic [9:0] trialCode,
   input wire logic [9:0] vin,
   output logic cmpOut
);
   logic [9:0] held_q;
   logic junk_q = 1'h0;
   // Hold capacitor follows the input only while sampling
   always_ff @(posedge core_clk) begin
      if (analogPowerOn && sampleActive) begin
         held_q <= vin;
      end
      junk_q <= ~junk_q;
   end
   // An unpowered comparator gives a toggling level, never a stale answer
   assign cmpOut = analogPowerOn ? (held_q >= trialCode) : junk_q;
endmodule

// ==== verification/acc_top_asserts.sv ====
`timescale 1ns/1ps
// Port-level checks on the conversion control block
module acc_top_asserts (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sleepActive,
   input wire logic specialEventTrig,
   input wire logic timerOneClear,
   input wire logic wakeRequest,
   input wire logic convDonePulse,
   input wire logic analogPowerOn,
   input wire logic sampleActive,
   input wire logic [9:0] trialCode,
   input wire logic [3:0] extChannel,
   input wire logic extChannelEn,
   input wire logic tempSel,
   input wire logic dacSel,
   input wire logic fvrSel,
   input wire logic [1:0] posRefSel,
   input wire logic posRefValid
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Sampling ends while the core is powered
   sequence s_sample_end;
      analogPowerOn && $fell(sampleActive);
   endsequence
   property p_trig_clear;
      specialEventTrig |=> timerOneClear;
   endproperty
   a_trig_clear: assert property (p_trig_clear)
      else $error("timer clear missing after trigger");
   property p_ref_valid;
      posRefValid == (posRefSel != 2'h1);
   endproperty
   a_ref_valid: assert property (p_ref_valid)
      else $error("reserved positive reference reported valid");
   property p_chan_onehot;
      $onehot0({extChannelEn, tempSel, dacSel, fvrSel});
   endproperty
   a_chan_onehot: assert property (p_chan_onehot)
      else $error("more than one channel routed");
   property p_ext_range;
      extChannelEn |-> extChannel <= 4'hD;
   endproperty
   a_ext_range: assert property (p_ext_range)
      else $error("external channel beyond last input");
   property p_wake_sleep;
      wakeRequest |-> $past(sleepActive);
   endproperty
   a_wake_sleep: assert property (p_wake_sleep)
      else $error("wake request while awake");
   // First trial after sampling tests only the top bit
   property p_first_trial;
      s_sample_end |-> ##[0:1] trialCode == 10'h200;
   endproperty
   a_first_trial: assert property (p_first_trial)
      else $error("first trial code is not the top bit");
   property p_done_pulse;
      convDonePulse |=> !convDonePulse;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("completion pulse longer than one cycle");
   property p_off_no_sample;
      !analogPowerOn [*2] |-> !sampleActive;
   endproperty
   a_off_no_sample: assert property (p_off_no_sample)
      else $error("sampling while the core is unpowered");
endmodule
bind acc_top acc_top_asserts acc_top_asserts_inst (
   .core_clk(core_clk), .rst(rst), .sleepActive(sleepActive),
   .specialEventTrig(specialEventTrig), .timerOneClear(timerOneClear),
   .wakeRequest(wakeRequest), .convDonePulse(convDonePulse), .analogPowerOn(analogPowerOn),
   .sampleActive(sampleActive), .trialCode(trialCode), .extChannel(extChannel),
   .extChannelEn(extChannelEn), .tempSel(tempSel), .dacSel(dacSel), .fvrSel(fvrSel),
   .posRefSel(posRefSel), .posRefValid(posRefValid)
);

// ==== verification/tb_adc_conversion_control.sv ====
`timescale 1ns/1ps
// Self-checking bench for the conversion control block
module tb_adc_conversion_control;
   import acc_pkg::*;
   localparam int RCH = 2;
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic sleepActive = 1'h0;
   logic specialEventTrig = 1'h0;
   logic [9:0] vin = 10'h0;
   logic hreadyout, hresp, timerOneClear, wakeRequest, convDonePulse, cmpOut;
   logic analogPowerOn, sampleActive, extChannelEn, tempSel, dacSel, fvrSel;
   logic negRefExt, posRefValid;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic [9:0] trialCode;
   logic [3:0] extChannel;
   logic [1:0] posRefSel;
   logic [9:0] v;
   int errors = 0;
   int n_tests = 0;
   int seed = 85;
   int n;
   acc_top #(.RC_HALF(RCH)) acc_top_inst (
      .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleepActive(sleepActive),
      .specialEventTrig(specialEventTrig), .timerOneClear(timerOneClear),
      .wakeRequest(wakeRequest), .convDonePulse(convDonePulse), .cmpOut(cmpOut),
      .analogPowerOn(analogPowerOn), .sampleActive(sampleActive), .trialCode(trialCode),
      .extChannel(extChannel), .extChannelEn(extChannelEn), .tempSel(tempSel),
      .dacSel(dacSel), .fvrSel(fvrSel), .negRefExt(negRefExt), .posRefSel(posRefSel),
      .posRefValid(posRefValid)
   );
   acc_analog_model acc_analog_model_inst (
      .core_clk(core_clk), .analogPowerOn(analogPowerOn), .sampleActive(sampleActive),
      .trialCode(trialCode), .vin(vin), .cmpOut(cmpOut)
   );
   // Free-running core clock
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic hang(input string what);
      errors++;
      $display("Error at %0t: timeout on %s", $time, what);
      end_of_test();
   endtask
   // Bounded wait for an edge with hready high
   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (hreadyout !== 1'h1 && k < 64);
      if (hreadyout !== 1'h1) begin
         hang("bus");
      end
   endtask
   // Single word transfer: address phase, then data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge core_clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'h1, a, d, q);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string what);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, q);
      chk(q, e, what);
      chk({31'h0, hresp}, 32'h0, "bus response");
   endtask
   // Counts cycles until the chosen pulse shows, with a bound
   task automatic wait_pulse(input logic wake, output int c);
      c = 0;
      do begin
         @(posedge core_clk);
         c++;
      end while ((wake ? wakeRequest : convDonePulse) !== 1'h1 && c < 2000);
      if (c >= 2000) begin
         hang("completion");
      end
   endtask
   task automatic trig();
      @(posedge core_clk);
      specialEventTrig <= 1'h1;
      @(posedge core_clk);
      specialEventTrig <= 1'h0;
      @(negedge core_clk);
   endtask
   function automatic logic [15:0] fmt(input logic just, input logic [9:0] r);
      return just ? {6'h0, r} : {r, 6'h0};
   endfunction
   function automatic int half_of(input logic [2:0] cs);
      case (cs)
         3'h0: return 1;
         3'h4: return 2;
         3'h1: return 4;
         3'h5: return 8;
         3'h2: return 16;
         3'h6: return 32;
         default: return RCH;
      endcase
   endfunction
   function automatic logic [7:0] chan_exp(input logic [4:0] c);
      return {c <= CHAN_LAST_EXT, (c <= CHAN_LAST_EXT) ? c[3:0] : 4'h0, c == CHAN_TEMP,
              c == CHAN_DAC, c == CHAN_FVR};
   endfunction
   // Full conversion on a random channel, checking length, flags and result layout
   task automatic conv(input logic just, input logic [2:0] cs, input logic [9:0] val);
      int c;
      int base;
      logic [4:0] ch;
      logic [15:0] e;
      ch = 5'($unsigned($random(seed)) % 14);
      e = fmt(just, val);
      base = 23 * half_of(cs) + ((cs[1:0] == CS_RC_LOW) ? INSTR_CYCLE_CLKS : 0);
      vin <= val;
      wr(OFS_CTRL_ONE, {24'h0, just, cs, 4'h0});
      wr(OFS_STATUS, 32'h0);
      wr(OFS_CTRL_ZERO, {25'h0, ch, 2'h3});
      wait_pulse(1'h0, c);
      chk(32'(c >= base && c <= base + 4), 32'h1, "conversion length");
      rdchk(OFS_CTRL_ZERO, {25'h0, ch, 2'h1}, "go after completion");
      rdchk(OFS_STATUS, 32'h1, "done flag");
      rdchk(OFS_RES_HIGH, {24'h0, e[15:8]}, "result high");
      rdchk(OFS_RES_LOW, {24'h0, e[7:0]}, "result low");
   endtask
   initial begin
      #2000000;
      hang("run");
   end
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'h0;
      rdchk(OFS_CTRL_ZERO, 32'h0, "ctrl zero reset");
      rdchk(OFS_CTRL_ONE, 32'h0, "ctrl one reset");
      wr(8'h14, 32'hFFFF_FFFF);
      rdchk(8'h14, 32'h0, "unmapped");
      wr(OFS_CTRL_ONE, 32'hFF);
      rdchk(OFS_CTRL_ONE, 32'hF7, "ctrl one unused bit");
      wr(OFS_CTRL_ZERO, 32'hFC);
      rdchk(OFS_CTRL_ZERO, 32'h7C, "ctrl zero unused bit");
      for (int i = 0; i < 32; i++) begin
         wr(OFS_CTRL_ZERO, {25'h0, 5'(i), 2'h0});
         @(negedge core_clk);
         chk({24'h0, extChannelEn, extChannelEn ? extChannel : 4'h0, tempSel, dacSel,
              fvrSel}, {24'h0, chan_exp(5'(i))}, "channel");
      end
      for (int i = 0; i < 8; i++) begin
         wr(OFS_CTRL_ONE, {29'h0, 3'(i)});
         @(negedge core_clk);
         chk({28'h0, negRefExt, posRefSel, posRefValid},
             {28'h0, i[2], i[1:0], i[1:0] != 2'h1}, "reference");
      end
      $display("Test registers done");
      for (int i = 0; i < 8; i++) begin
         conv(i[0], 3'(i), 10'($random(seed)));
      end
      conv(1'h0, CS_DIV2, 10'h3FF);
      conv(1'h1, CS_DIV4, 10'h000);
      $display("Test conversions done");
      wr(OFS_CTRL_ONE, 32'h0);
      wr(OFS_CTRL_ZERO, 32'h2);
      rdchk(OFS_CTRL_ZERO, 32'h0, "go while disabled");
      trig();
      chk({31'h0, timerOneClear}, 32'h1, "timer clear");
      rdchk(OFS_CTRL_ZERO, 32'h0, "trigger while disabled");
      wr(OFS_CTRL_ZERO, 32'h1);
      trig();
      chk({31'h0, timerOneClear}, 32'h1, "timer clear");
      rdchk(OFS_CTRL_ZERO, 32'h3, "trigger sets go");
      n = 0;
      do begin
         bus(1'h0, OFS_CTRL_ZERO, 32'h0, rd);
         n++;
      end while (rd[CZ_GO_BIT] !== 1'h0 && n < 100);
      // A poll that never sees go drop is a hang, not a pass
      if (rd[CZ_GO_BIT] !== 1'h0) begin
         hang("go poll");
      end
      rdchk(OFS_STATUS, 32'h1, "done after trigger");
      wr(OFS_STATUS, 32'h0);
      rdchk(OFS_STATUS, 32'h0, "done cleared");
      $display("Test trigger done");
      vin <= 10'h3FF;
      wr(OFS_CTRL_ONE, 32'hE0);
      wr(OFS_CTRL_ZERO, 32'h3);
      repeat (200) @(posedge core_clk);
      wr(OFS_CTRL_ZERO, 32'h1);
      rdchk(OFS_CTRL_ZERO, 32'h1, "abort clears go");
      rdchk(OFS_RES_HIGH, 32'h3, "partial high");
      rdchk(OFS_RES_LOW, 32'hFF, "partial low");
      rdchk(OFS_STATUS, 32'h0, "no done on abort");
      wr(OFS_CTRL_ONE, 32'h0);
      wr(OFS_CTRL_ZERO, 32'h3);
      repeat (6) @(posedge core_clk);
      sleepActive <= 1'h1;
      repeat (3) @(negedge core_clk);
      chk({31'h0, analogPowerOn}, 32'h0, "sleep power down");
      rdchk(OFS_CTRL_ZERO, 32'h1, "sleep abort keeps enable");
      sleepActive <= 1'h0;
      v = 10'($random(seed));
      vin <= v;
      wr(OFS_CTRL_ONE, 32'h30);
      wr(OFS_STATUS, 32'h2);
      wr(OFS_CTRL_ZERO, 32'h3);
      sleepActive <= 1'h1;
      wait_pulse(1'h1, n);
      sleepActive <= 1'h0;
      rdchk(OFS_RES_HIGH, {24'h0, v[9:2]}, "result in sleep");
      rdchk(OFS_STATUS, 32'h3, "done in sleep");
      wr(OFS_STATUS, 32'h0);
      wr(OFS_CTRL_ZERO, 32'h3);
      sleepActive <= 1'h1;
      wait_pulse(1'h0, n);
      repeat (3) @(negedge core_clk);
      chk({31'h0, analogPowerOn}, 32'h0, "off after sleep conversion");
      rdchk(OFS_CTRL_ZERO, 32'h1, "enable stays set");
      sleepActive <= 1'h0;
      $display("Test sleep done");
      end_of_test();
   end
endmodule
